// file: inc/pls_pkg.sv
// Constants, register map and carrier types for the programmable sum-of-products array.
// Assumes a single AHB-Lite slave port with 32-bit data and word-aligned registers.
package pls_pkg;

  localparam int NUM_IN = 12;
  localparam int NUM_MC = 10;
  localparam int NUM_SIG = NUM_IN + NUM_MC;
  localparam int NUM_COL = 2 * NUM_SIG;
  localparam int PT_CNT [NUM_MC] = '{8, 10, 12, 14, 16, 16, 14, 12, 10, 8};
  localparam int NUM_PT = 132;
  localparam int PT_AR = 0;
  localparam int PT_SP = NUM_PT - 1;
  localparam int HI_W = NUM_COL - 32;

  localparam logic [7:0] ADDR_CFG = 8'h00;
  localparam logic [7:0] ADDR_SEL = 8'h04;
  localparam logic [7:0] ADDR_PT_LO = 8'h08;
  localparam logic [7:0] ADDR_PT_HI = 8'h0C;
  localparam logic [7:0] ADDR_STATE = 8'h10;
  localparam logic [7:0] SEL_LIMIT = 8'h84;

  localparam logic [31:0] CFG_MASK = 32'h03FF_03FF;
  localparam logic [31:0] CFG_RST = 32'h0000_0000;
  localparam logic [7:0] SEL_RST = 8'h00;
  localparam logic [NUM_COL-1:0] FUSE_RST = '1;

  // Both configuration words share one layout: macrocell bits low, second field at bit 16.
  typedef struct packed {
    logic [5:0] rsv_hi;
    logic [NUM_MC-1:0] byp;
    logic [5:0] rsv_lo;
    logic [NUM_MC-1:0] pol;
  } pls_cfg_t;

  typedef struct packed {
    logic [5:0] rsv_hi;
    logic [NUM_MC-1:0] pin;
    logic [5:0] rsv_lo;
    logic [NUM_MC-1:0] q;
  } pls_state_t;

  // First product term of a macrocell: its output-enable term, then its sum terms.
  function automatic int pt_base(input int c);
    int b;
    b = 1;
    for (int j = 0; j < c; j++) begin
      b = b + PT_CNT[j] + 1;
    end
    return b;
  endfunction

endpackage

// file: rtl/pls_macrocell_array.sv
// Programmable AND array, fixed OR groups and ten output macrocells behind an AHB-Lite slave.
// Assumes the board resolves each I/O pin from io_out and io_oe and returns the level on io_in.
`timescale 1ns/100ps
`default_nettype none

module pls_macrocell_array
  import pls_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire logic [NUM_IN-1:0] in_pins,
  input wire logic [NUM_MC-1:0] io_in,
  output logic [NUM_MC-1:0] io_out,
  output logic [NUM_MC-1:0] io_oe
);

  // A term is the AND of every literal whose link is still intact.
  function automatic logic and_term(input logic [NUM_COL-1:0] fuse, input logic [NUM_COL-1:0] lit_v);
    return &(~fuse | lit_v);
  endfunction

  pls_cfg_t cfg_ff;
  logic [7:0] sel_ff;
  logic [NUM_COL-1:0] pt_ff [NUM_PT];
  logic [NUM_MC-1:0] q_ff;
  logic pend_ff;
  logic wr_ff;
  logic [7:0] areg_ff;
  logic rdy_ff;
  logic [31:0] hrdata_ff;
  logic hresp_ff;

  logic [NUM_SIG-1:0] sig;
  logic [NUM_COL-1:0] lit;
  logic [NUM_PT-1:0] pt_val;
  logic [NUM_MC-1:0] fb;
  logic [NUM_MC-1:0] or_sum;
  logic [NUM_MC-1:0] oe_term;
  logic [NUM_MC-1:0] q_eff;
  logic [NUM_MC-1:0] nxt_q;
  logic [NUM_MC-1:0] pin_val;
  logic ar_term;
  logic sp_term;

  // Array inputs: dedicated pins low, macrocell feedback above them.
  assign sig = {fb, in_pins};

  genvar k;
  generate
    for (k = 0; k < NUM_SIG; k++) begin : g_lit
      assign lit[2*k] = sig[k];
      assign lit[2*k+1] = ~sig[k];
    end
  endgenerate

  genvar t;
  generate
    for (t = 0; t < NUM_PT; t++) begin : g_pt
      assign pt_val[t] = and_term(pt_ff[t], lit);
    end
  endgenerate

  genvar c;
  generate
    for (c = 0; c < NUM_MC; c++) begin : g_mc
      localparam int B = pt_base(c);
      localparam int N = PT_CNT[c];
      assign oe_term[c] = pt_val[B];
      assign or_sum[c] = |pt_val[B+1 +: N];
    end
  endgenerate

  assign ar_term = pt_val[PT_AR];
  assign sp_term = pt_val[PT_SP];

  // The reset term masks Q at once; the flops themselves clear on the next edge.
  assign q_eff = ar_term ? '0 : q_ff;
  assign nxt_q = ar_term ? '0 : (sp_term ? '1 : or_sum);

  // Feedback uses the raw flop so the reset term cannot loop back through itself.
  assign fb = (cfg_ff.byp & io_in) | (~cfg_ff.byp & q_ff);
  assign pin_val = (cfg_ff.byp & or_sum) | (~cfg_ff.byp & q_eff);

  // Pin paths stay combinational: a registered pin would delay the combinatorial configuration.
  assign io_out = ~(cfg_ff.pol ^ pin_val);
  assign io_oe = oe_term;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      q_ff <= '0;
    end else begin
      q_ff <= nxt_q;
    end
  end

  // Bus slave: each access takes one wait state, so a read always sees a preceding write.
  logic acc;
  logic wr_en;
  logic sel_ok;
  logic [NUM_COL-1:0] pt_sel;
  logic [31:0] rd_mux;
  pls_state_t state_w;

  assign acc = hsel & hready & htrans[1];
  assign wr_en = pend_ff & wr_ff;
  assign sel_ok = sel_ff < SEL_LIMIT;
  assign pt_sel = sel_ok ? pt_ff[sel_ff] : '0;
  assign state_w = '{rsv_hi: 6'h00, pin: io_out, rsv_lo: 6'h00, q: q_eff};
  assign rd_mux = (areg_ff == ADDR_CFG) ? cfg_ff :
                  (areg_ff == ADDR_SEL) ? {24'h000000, sel_ff} :
                  (areg_ff == ADDR_PT_LO) ? pt_sel[31:0] :
                  (areg_ff == ADDR_PT_HI) ? {20'h00000, pt_sel[NUM_COL-1:32]} :
                  (areg_ff == ADDR_STATE) ? state_w : 32'h0000_0000;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pend_ff <= 1'b0;
      wr_ff <= 1'b0;
      areg_ff <= 8'h00;
      rdy_ff <= 1'b1;
      hrdata_ff <= 32'h0000_0000;
      hresp_ff <= 1'b0;
    end else if (acc) begin
      pend_ff <= 1'b1;
      wr_ff <= hwrite;
      areg_ff <= haddr[7:0];
      rdy_ff <= 1'b0;
    end else if (pend_ff) begin
      pend_ff <= 1'b0;
      rdy_ff <= 1'b1;
      if (!wr_ff) begin
        hrdata_ff <= rd_mux;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cfg_ff <= CFG_RST;
      sel_ff <= SEL_RST;
    end else if (wr_en) begin
      if (areg_ff == ADDR_CFG) begin
        cfg_ff <= hwdata & CFG_MASK;
      end
      if (areg_ff == ADDR_SEL) begin
        sel_ff <= hwdata[7:0];
      end
    end
  end

  // A set bit is an intact link; reset leaves every link intact, so every term reads low.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int i = 0; i < NUM_PT; i++) begin
        pt_ff[i] <= FUSE_RST;
      end
    end else if (wr_en && sel_ok) begin
      if (areg_ff == ADDR_PT_LO) begin
        pt_ff[sel_ff][31:0] <= hwdata;
      end
      if (areg_ff == ADDR_PT_HI) begin
        pt_ff[sel_ff][NUM_COL-1:32] <= hwdata[HI_W-1:0];
      end
    end
  end

  assign hreadyout = rdy_ff;
  assign hrdata = hrdata_ff;
  assign hresp = hresp_ff;

  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  AST_EMPTY_TERM_HIGH: assert property (pt_ff[PT_AR] == '0 |-> ar_term)
    else $error("Term with all links removed is not high.");
  AST_CONTRA_TERM_LOW: assert property ((pt_ff[PT_SP][0] && pt_ff[PT_SP][1]) |-> !sp_term)
    else $error("Term with both polarities of one input is not low.");
  AST_CAPTURE: assert property ((!ar_term && !sp_term) |=> q_ff == $past(or_sum))
    else $error("Flip-flop did not capture the OR result.");
  AST_PRESET: assert property ((sp_term && !ar_term) |=> q_ff == '1)
    else $error("Preset term did not set every flip-flop.");
  AST_RESET_NOW: assert property (ar_term |-> (q_eff == '0) ##1 (q_ff == '0))
    else $error("Reset term did not clear the flip-flops.");
  AST_REG_PATH: assert property ((!ar_term && !sp_term && $stable(cfg_ff)) ##1 !ar_term
    |-> (~cfg_ff.byp & (io_out ^ ~($past(or_sum) ^ cfg_ff.pol))) == '0)
    else $error("Registered pin does not follow the captured state.");
  AST_REG_FEEDBACK: assert property ((~cfg_ff.byp & (fb ^ q_ff)) == '0)
    else $error("Registered feedback is not the flip-flop output.");
  AST_COMB_PATH: assert property ((cfg_ff.byp & (io_out ^ ~(or_sum ^ cfg_ff.pol))) == '0)
    else $error("Combinatorial pin does not follow the OR result.");
  AST_COMB_FEEDBACK: assert property ((cfg_ff.byp & (fb ^ io_in)) == '0)
    else $error("Combinatorial feedback is not the pin.");
  AST_ENABLE: assert property (io_oe == oe_term)
    else $error("Output enable is not its product term.");
  AST_POWER_UP: assert property ($rose(hresetn) |-> q_ff == '0 && cfg_ff == CFG_RST)
    else $error("Flip-flops or select bits not low after reset.");
  AST_BUS_WAIT: assert property (acc |=> !hreadyout ##1 hreadyout)
    else $error("Bus access did not take exactly one wait state.");

  // The checks below cover the pin and feedback paths, the flops, the OR groups and the bus registers.
  // The pin-polarity checks read the effective state, so the reset term's masking is covered as well.
  AST_POL_REG: assert property (
    (~cfg_ff.byp & (io_out ^ ~(q_eff ^ cfg_ff.pol))) == '0)
    else $error("Registered pin polarity does not follow the select bit.");

  AST_RESET_PIN: assert property (ar_term |->
    (~cfg_ff.byp & (io_out ^ ~cfg_ff.pol)) == '0)
    else $error("Registered pin under reset term does not follow polarity.");

  AST_PRESET_PIN: assert property ((sp_term && !ar_term) ##1 !ar_term |->
    (~cfg_ff.byp & (io_out ^ cfg_ff.pol)) == '0)
    else $error("Registered pin after preset does not follow polarity.");

  AST_INPUT_ONLY: assert property (
    (~io_oe & cfg_ff.byp & (fb ^ io_in)) == '0)
    else $error("Undriven combinatorial pin is not used as an input.");

  AST_RESET_WINS: assert property ((ar_term && sp_term) |=>
    q_ff == '0)
    else $error("Preset term overrode the reset term.");

  AST_SAME_EDGE: assert property ((!ar_term && !sp_term && or_sum == '1) |=>
    q_ff == '1)
    else $error("Flip-flops did not all load on the same edge.");

  AST_CONTRA_ANY: assert property (
    (pt_ff[PT_AR][NUM_COL-1 -: 2] == 2'b11) |-> !ar_term)
    else $error("Term with both feedback polarities is not low.");

  AST_EMPTY_SP: assert property (
    (pt_ff[PT_SP] == '0) |-> sp_term)
    else $error("Preset term with all links removed is not high.");

  AST_SIG_ORDER: assert property (
    sig[NUM_IN-1:0] == in_pins && sig[NUM_SIG-1:NUM_IN] == fb)
    else $error("Array inputs are not the pins followed by feedback.");

  AST_LIT_PAIRS: assert property (
    (lit[0] != lit[1]) && (lit[NUM_COL-2] != lit[NUM_COL-1]))
    else $error("An array input is missing one of its polarities.");

  AST_OR_ZERO: assert property (
    (pt_val[NUM_PT-2:1] == '0) |-> or_sum == '0)
    else $error("A sum is high with every term low.");

  AST_OR_WIDE: assert property (
    (|pt_val[pt_base(4)+1 +: PT_CNT[4]]) |-> or_sum[4])
    else $error("The widest group does not sum its terms.");

  AST_OR_NARROW: assert property (
    (pt_val[pt_base(0)+1 +: PT_CNT[0]] == '0) |-> !or_sum[0])
    else $error("The narrowest group sums a term it does not own.");

  AST_CFG_RESERVED: assert property (
    cfg_ff.rsv_hi == '0 && cfg_ff.rsv_lo == '0)
    else $error("Reserved select bits are not zero.");

  AST_WRITE_CFG: assert property ((wr_en && areg_ff == ADDR_CFG) |=>
    cfg_ff == ($past(hwdata) & CFG_MASK))
    else $error("Select bits did not take the written word.");

  AST_WRITE_SEL: assert property ((wr_en && areg_ff == ADDR_SEL) |=>
    sel_ff == $past(hwdata[7:0]))
    else $error("Term index did not take the written byte.");

  AST_WRITE_PT: assert property ((wr_en && sel_ok && areg_ff == ADDR_PT_LO) |=>
    pt_ff[$past(sel_ff)][31:0] == $past(hwdata))
    else $error("Low links of the selected term were not written.");

  AST_CFG_KEEP: assert property (!wr_en |=>
    $stable(cfg_ff) && $stable(sel_ff))
    else $error("Select bits changed without a write.");

  AST_PT_KEEP: assert property (!wr_en |=>
    $stable(pt_ff[PT_AR]) && $stable(pt_ff[PT_SP]))
    else $error("Reset or preset links changed without a write.");

  AST_SEL_GUARD: assert property (
    !sel_ok |-> pt_sel == '0)
    else $error("Out-of-range term index does not read zero.");

  AST_HRESP_OKAY: assert property (
    hresp == 1'b0)
    else $error("Bus response is not OKAY.");

  AST_READY_PEND: assert property (
    hreadyout == !pend_ff)
    else $error("Ready is not low exactly while an access is pending.");

  AST_RDATA_HOLD: assert property (!(pend_ff && !wr_ff) |=>
    $stable(hrdata))
    else $error("Read data changed outside a read.");

  AST_READ_LOAD: assert property ((pend_ff && !wr_ff) |=>
    hrdata == $past(rd_mux))
    else $error("Read data is not the addressed register.");


  COV_PRESET: cover property (sp_term ##1 q_ff == '1);
  COV_RESET: cover property (ar_term && q_ff != '0);
  COV_BIDIR: cover property (|(cfg_ff.byp & oe_term));
  COV_WRITE: cover property (acc && hwrite ##2 hreadyout);
  COV_INPUT_ONLY: cover property (|(cfg_ff.byp & ~io_oe));

endmodule

`default_nettype wire

// file: test/pls_board.sv
// Board model for the I/O pins of the sum-of-products array.
// Assumes a pull-up on every I/O pin; the bench may drive a pin that the array leaves off.
`timescale 1ns/100ps
`default_nettype none
module pls_board
  import pls_pkg::*;
(
  input wire logic [NUM_MC-1:0] io_out,
  input wire logic [NUM_MC-1:0] io_oe,
  input wire logic [NUM_MC-1:0] drv_en,
  input wire logic [NUM_MC-1:0] drv_val,
  output logic [NUM_MC-1:0] io_in
);
  // A pin that nobody drives settles high through its pull-up.
  assign io_in = (io_oe & io_out) | (~io_oe & (drv_val | ~drv_en));
endmodule
`default_nettype wire

// file: test/test_programmable_sum_of_products_macrocells.sv
// Self-checking bench for the sum-of-products array, reached over AHB-Lite.
// Assumes one bus slave, so hready is its own hreadyout; pins resolve through the board model.
`timescale 1ns/100ps
`default_nettype none
module test_programmable_sum_of_products_macrocells;
  import pls_pkg::*;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic [31:0] r;
  logic hreadyout;
  logic hresp;
  logic [NUM_IN-1:0] in_pins = '0;
  logic [NUM_MC-1:0] io_in;
  logic [NUM_MC-1:0] io_out;
  logic [NUM_MC-1:0] io_oe;
  logic [NUM_MC-1:0] drv_en = '0;
  logic [NUM_MC-1:0] drv_val = '0;
  int fail_count = 0;
  int n_tests = 0;
  always #5 hclk = ~hclk;
  pls_macrocell_array dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hrdata(hrdata), .hresp(hresp), .in_pins(in_pins), .io_in(io_in), .io_out(io_out), .io_oe(io_oe));
  pls_board board (.io_out(io_out), .io_oe(io_oe), .drv_en(drv_en), .drv_val(drv_val), .io_in(io_in));
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    n_tests++;
    if (s !== e) begin
      fail_count++;
      $display("[FAIL] %s exp %h got %h", nm, e, s);
    end
  endtask
  // Read data lands in r; hsel stays up between transfers, a stuck bus is left to the watchdog.
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    hwrite <= w;
    haddr <= {24'h000000, a};
    htrans <= 2'h2;
    do begin
      @(posedge hclk);
    end while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do begin
      @(posedge hclk);
    end while (hreadyout !== 1'b1);
    r = hrdata;
  endtask
  task automatic prog(input logic [7:0] i, input logic [31:0] lo, input logic [11:0] hi);
    bus(1'b1, ADDR_SEL, {24'h000000, i});
    bus(1'b1, ADDR_PT_LO, lo);
    bus(1'b1, ADDR_PT_HI, {20'h00000, hi});
  endtask
  task automatic t_reset;
    bus(1'b0, ADDR_CFG, 32'h0);
    chk("cfg", 32'h0000_0000, r);
    bus(1'b0, ADDR_STATE, 32'h0);
    chk("state", 32'h03FF_0000, r);
    chk("oe", 32'h0, {22'h0, io_oe});
    bus(1'b1, 8'h14, 32'hFFFF_FFFF);
    bus(1'b0, 8'h14, 32'h0);
    chk("unmapped", 32'h0, r);
    chk("hresp", 32'h0, {31'h0, hresp});
    bus(1'b1, ADDR_SEL, {24'h000000, SEL_LIMIT});
    bus(1'b0, ADDR_SEL, 32'h0);
    chk("sel", {24'h000000, SEL_LIMIT}, r);
    bus(1'b1, ADDR_PT_LO, 32'h0);
    bus(1'b0, ADDR_PT_LO, 32'h0);
    chk("pt_refused", 32'h0, r);
    $display("t_reset done");
  endtask
  // Cell 0: enable term 1, first sum term 2.
  task automatic t_comb;
    bus(1'b1, ADDR_CFG, 32'h0001_0001);
    prog(8'h01, 32'h0, 12'h000);
    prog(8'h02, 32'h0000_0001, 12'h000);
    for (int v = 0; v < 2; v++) begin
      in_pins <= {11'h000, v[0]};
      @(posedge hclk);
      #1;
      chk("comb", {31'h0, v[0]}, {31'h0, io_out[0]});
    end
    bus(1'b1, ADDR_CFG, 32'h0001_0000);
    #1;
    chk("comb_low", 32'h0, {31'h0, io_out[0]});
    chk("oe0", 32'h1, {31'h0, io_oe[0]});
    prog(8'h02, 32'h0000_0003, 12'h000);
    #1;
    chk("both_pol", 32'h1, {31'h0, io_out[0]});
    prog(8'h02, 32'h0, 12'h000);
    #1;
    chk("no_link", 32'h0, {31'h0, io_out[0]});
    $display("t_comb done");
  endtask
  // Cell 1 sums the pin of cell 0; cell 2 sums the flop of cell 1.
  task automatic t_reg;
    drv_en <= 10'h001;
    drv_val <= 10'h000;
    prog(8'h01, 32'hFFFF_FFFF, 12'hFFF);
    bus(1'b1, ADDR_CFG, 32'h0001_0006);
    prog(8'h0B, 32'h0100_0000, 12'h000);
    prog(8'h16, 32'h0400_0000, 12'h000);
    repeat (2) @(posedge hclk);
    #1;
    chk("reg0", 32'h0, {30'h0, io_out[2:1]});
    chk("in_only", 32'h0, {31'h0, io_oe[0]});
    @(posedge hclk);
    drv_val <= 10'h001;
    @(posedge hclk);
    #1;
    chk("reg1", 32'h1, {30'h0, io_out[2:1]});
    @(posedge hclk);
    #1;
    chk("fb_q", 32'h3, {30'h0, io_out[2:1]});
    $display("t_reg done");
  endtask
  task automatic t_init;
    prog(8'h83, 32'h0, 12'h000);
    @(posedge hclk);
    bus(1'b0, ADDR_STATE, 32'h0);
    chk("preset", 32'h3FF, {22'h0, r[9:0]});
    #1;
    chk("pol_pin", 32'h1, {30'h0, io_out[3], io_out[1]});
    prog(8'h00, 32'h0, 12'h000);
    bus(1'b0, ADDR_STATE, 32'h0);
    chk("reset", 32'h0, {22'h0, r[9:0]});
    #1;
    chk("rst_pin", 32'h1, {31'h0, io_out[3]});
    $display("t_init done");
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_reset;
    t_comb;
    t_reg;
    t_init;
    tally_and_finish;
  end
  initial begin
    #100000;
    fail_count++;
    tally_and_finish;
  end
endmodule
`default_nettype wire
